// ===== src/rx_glue_pkg.sv
// constants shared by the receiver pin control block and its testbench
// assumes one 20 MHz system clock and a classic wishbone register port
package rx_glue_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_LINES = 8'h04;
    localparam logic [7:0] OFS_SYMDIV = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // config fields
    localparam int CFG_EXT_ADC = 0;
    localparam int CFG_TWOS = 1;
    localparam int CFG_MODE_LO = 2;

    // lines fields
    localparam int LN_L1 = 0;
    localparam int LN_L2 = 1;
    localparam int LN_L3 = 2;
    localparam int LN_L4_OUT = 3;
    localparam int LN_L4_DIR = 4;
    localparam int LN_L4_IN = 8;

    // status fields
    localparam int ST_PWM = 8;
    localparam int ST_VALID = 9;

    // reset values
    localparam logic [3:0] LINES_RESET = 4'h1;
    localparam logic [15:0] SYMDIV_RESET = 16'h0001;

    // timing counts, clock period and data widths
    localparam logic [1:0] RST_EDGES = 2'h3;
    localparam int PWM_DIV = 8;
    localparam int AGC_SYMBOLS = 2048;
    localparam int SAMPLE_W = 6;
    localparam int BYTE_W = 8;
    localparam int CLK_PERIOD_NS = 50;

    typedef enum logic [1:0] {
        OUT_PAR_CONT = 2'b00,
        OUT_PAR_GATED = 2'b01,
        OUT_SERIAL = 2'b10
    } out_mode_e;
endpackage : rx_glue_pkg

// ===== src/byte_buffer.sv
// small fifo between the decoded byte source and the output pins
// assumes a single clock and an active high asynchronous reset
`timescale 1ns/10ps
module byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } buf_s;

    buf_s st_reg;
    buf_s st_next;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    assign in_ready_o = (st_reg.count != (AW + 1)'(DEPTH));
    assign out_valid_o = (st_reg.count != '0);
    assign out_data_o = st_reg.mem[st_reg.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data_i;
            st_next.wr = bump(st_reg.wr);
        end
        if (pop) begin
            st_next.rd = bump(st_reg.rd);
        end
        st_next.count = st_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    a_buf_bounds: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        push && !pop |=> st_reg.count == $past(st_reg.count) + 1)
        else $error("buffer count did not grow on push");
endmodule : byte_buffer

// ===== src/rx_pin_glue.sv
// pin level control of the channel receiver: clear, sample clock, sample capture,
// gain pwm, four control lines and the decoded byte output port
// assumes a wishbone master, an agc estimator and a decoder feeding bytes
`timescale 1ns/10ps
module rx_pin_glue #(
    parameter int SAMPLE_HALF = 1,
    parameter int BYTE_CLOCK_OUT_HALF = 2,
    parameter int BUF_DEPTH = 2
) (
    // clock and clear (clear is the active high form of the pin)
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // external converter
    output logic sample_clock_out_o,
    input wire logic [rx_glue_pkg::SAMPLE_W-1:0] sample_i_i,
    input wire logic [rx_glue_pkg::SAMPLE_W-1:0] sample_q_i,
    output logic [rx_glue_pkg::SAMPLE_W-1:0] sample_i_o,
    output logic [rx_glue_pkg::SAMPLE_W-1:0] sample_q_o,
    output logic sample_valid_o,
    // gain control
    input wire logic [7:0] gain_level_i,
    output logic gain_pwm_out_o,
    // control lines
    output logic control_line_1_o,
    output logic control_line_1_oe_o,
    output logic control_line_2_o,
    output logic control_line_2_oe_o,
    output logic control_line_3_o,
    output logic control_line_3_oe_o,
    input wire logic control_line_4_i,
    output logic control_line_4_o,
    output logic control_line_4_oe_o,
    // decoded byte source
    input wire logic byte_in_valid_i,
    output logic byte_in_ready_o,
    input wire logic [rx_glue_pkg::BYTE_W-1:0] byte_in_data_i,
    // decoded byte pins
    input wire logic byte_ready_i,
    output logic [rx_glue_pkg::BYTE_W-1:0] byte_data_out_o,
    output logic byte_valid_out_o,
    output logic byte_clock_out_o
);
    localparam int MIN_HOLD = rx_glue_pkg::PWM_DIV * 2 * SAMPLE_HALF;

    typedef struct packed {
        logic [1:0] rst_cnt;
        logic ready;
        logic ack;
        logic [31:0] rdata;
        logic ext_adc;
        logic twos;
        logic [1:0] omode;
        logic [3:0] lines;
        logic l4_dir;
        logic l4_in;
        logic [15:0] sym_div;
        logic [7:0] sdiv_cnt;
        logic sclk;
        logic [rx_glue_pkg::SAMPLE_W-1:0] i_s;
        logic [rx_glue_pkg::SAMPLE_W-1:0] q_s;
        logic s_valid;
        logic [2:0] tick_cnt;
        logic [3:0] pwm_phase;
        logic pwm;
        logic [15:0] sym_cnt;
        logic [10:0] agc_cnt;
        logic [7:0] gain;
        logic [7:0] odiv_cnt;
        logic byte_clock_out;
        logic [7:0] dout;
        logic dvalid;
        logic [7:0] shifter;
        logic [2:0] bit_cnt;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic buf_valid;
    logic buf_ready;
    logic buf_pop;
    logic [7:0] buf_data;
    logic bus_req;
    logic [31:0] lines_word;
    logic [15:0] hold_cnt;

    // samples are carried inside as two's complement
    function automatic logic [rx_glue_pkg::SAMPLE_W-1:0] to_signed(
        input logic [rx_glue_pkg::SAMPLE_W-1:0] raw, input logic twos);
        to_signed = twos ? raw : {~raw[rx_glue_pkg::SAMPLE_W-1],
                                  raw[rx_glue_pkg::SAMPLE_W-2:0]};
    endfunction : to_signed

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
        input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (val & m);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////////
    // byte buffer: a stalled receiver backs up into the decoder

    byte_buffer #(
        .WIDTH(rx_glue_pkg::BYTE_W),
        .DEPTH(BUF_DEPTH)
    ) u_buffer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(byte_in_valid_i && st_reg.ready),
        .in_ready_o(buf_ready),
        .in_data_i(byte_in_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop),
        .out_data_o(buf_data)
    );

    // no ready during the hold-off, so the decoder never thinks a dropped byte was taken
    assign byte_in_ready_o = buf_ready && st_reg.ready;
    assign lines_word = {23'h00_0000, st_reg.l4_in, 3'h0, st_reg.l4_dir, st_reg.lines};
    assign bus_req = wb_cyc_i && wb_stb_i && st_reg.ready && !st_reg.ack;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic sample_rise;
    logic ocl_rise;
    logic ocl_fire;
    logic sym_pulse;
    logic tick;
    logic [31:0] wr_word;

    always_comb begin
        st_next = st_reg;
        sample_rise = 1'b0;
        ocl_rise = 1'b0;
        ocl_fire = 1'b0;
        sym_pulse = 1'b0;
        tick = 1'b0;
        buf_pop = 1'b0;
        wr_word = '0;

        // hold off for three edges after the clear is released
        if (!st_reg.ready) begin
            st_next.rst_cnt = st_reg.rst_cnt + 2'h1;
            if (st_reg.rst_cnt == rx_glue_pkg::RST_EDGES - 2'h1) begin
                st_next.ready = 1'b1;
            end
        end

        // bus: one wait cycle, then a one-cycle ack; writes land at the ack edge
        st_next.ack = bus_req;
        if (bus_req) begin
            case (wb_adr_i)
                rx_glue_pkg::OFS_CONFIG: st_next.rdata = {28'h000_0000, st_reg.omode,
                                                          st_reg.twos, st_reg.ext_adc};
                rx_glue_pkg::OFS_LINES: st_next.rdata = lines_word;
                rx_glue_pkg::OFS_SYMDIV: st_next.rdata = {16'h0000, st_reg.sym_div};
                rx_glue_pkg::OFS_STATUS: st_next.rdata = {22'h00_0000, st_reg.dvalid,
                                                          st_reg.pwm, st_reg.gain};
                default: st_next.rdata = '0;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && st_reg.ack) begin
            case (wb_adr_i)
                rx_glue_pkg::OFS_CONFIG: begin
                    wr_word = merge({28'h000_0000, st_reg.omode, st_reg.twos,
                                     st_reg.ext_adc}, wb_dat_i, wb_sel_i);
                    st_next.ext_adc = wr_word[rx_glue_pkg::CFG_EXT_ADC];
                    st_next.twos = wr_word[rx_glue_pkg::CFG_TWOS];
                    st_next.omode = wr_word[rx_glue_pkg::CFG_MODE_LO +: 2];
                end
                rx_glue_pkg::OFS_LINES: begin
                    wr_word = merge(lines_word, wb_dat_i, wb_sel_i);
                    st_next.lines = wr_word[rx_glue_pkg::LN_L4_OUT:rx_glue_pkg::LN_L1];
                    st_next.l4_dir = wr_word[rx_glue_pkg::LN_L4_DIR];
                end
                rx_glue_pkg::OFS_SYMDIV: begin
                    wr_word = merge({16'h0000, st_reg.sym_div}, wb_dat_i, wb_sel_i);
                    st_next.sym_div = wr_word[15:0];
                end
                default: begin
                end
            endcase
        end

        // line 4 pin level, only meaningful while it is an input
        st_next.l4_in = st_reg.l4_dir ? st_reg.l4_in : control_line_4_i;

        // sample clock runs always; the pin only shows it for an external converter
        if (st_reg.sdiv_cnt == 8'(SAMPLE_HALF - 1)) begin
            st_next.sdiv_cnt = '0;
            st_next.sclk = !st_reg.sclk;
            sample_rise = !st_reg.sclk;
        end else begin
            st_next.sdiv_cnt = st_reg.sdiv_cnt + 8'h01;
        end
        st_next.s_valid = sample_rise && st_reg.ext_adc && st_reg.ready;
        if (st_next.s_valid) begin
            st_next.i_s = to_signed(sample_i_i, st_reg.twos);
            st_next.q_s = to_signed(sample_q_i, st_reg.twos);
        end

        // pwm steps once per eight sample periods, so its edges stay that far apart
        if (sample_rise) begin
            st_next.tick_cnt = st_reg.tick_cnt + 3'h1;
            tick = (st_reg.tick_cnt == 3'(rx_glue_pkg::PWM_DIV - 1));
            if (st_reg.sym_cnt == st_reg.sym_div) begin
                st_next.sym_cnt = '0;
                sym_pulse = 1'b1;
            end else begin
                st_next.sym_cnt = st_reg.sym_cnt + 16'h0001;
            end
        end
        if (tick) begin
            st_next.pwm_phase = st_reg.pwm_phase + 4'h1;
            st_next.pwm = (st_reg.pwm_phase < st_reg.gain[7:4]);
        end
        if (sym_pulse) begin
            st_next.agc_cnt = st_reg.agc_cnt + 11'h001;
            if (st_reg.agc_cnt == 11'(rx_glue_pkg::AGC_SYMBOLS - 1)) begin
                st_next.gain = gain_level_i;
            end
        end

        // byte clock; the gated form stands low while there is nothing to send
        if (st_reg.odiv_cnt == 8'(BYTE_CLOCK_OUT_HALF - 1)) begin
            st_next.odiv_cnt = '0;
            ocl_fire = 1'b1;
        end else begin
            st_next.odiv_cnt = st_reg.odiv_cnt + 8'h01;
        end
        if (ocl_fire) begin
            if (st_reg.omode != rx_glue_pkg::OUT_PAR_GATED || st_reg.byte_clock_out
                || buf_valid || st_reg.bit_cnt != 3'h0) begin
                st_next.byte_clock_out = !st_reg.byte_clock_out;
                ocl_rise = !st_reg.byte_clock_out;
            end
        end
        if (ocl_rise) begin
            if (st_reg.omode == rx_glue_pkg::OUT_SERIAL && st_reg.bit_cnt != 3'h0) begin
                st_next.shifter = {st_reg.shifter[6:0], 1'b0};
                st_next.dout = {7'h00, st_reg.shifter[7]};
                st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            end else if (buf_valid && byte_ready_i) begin
                buf_pop = 1'b1;
                st_next.dvalid = 1'b1;
                if (st_reg.omode == rx_glue_pkg::OUT_SERIAL) begin
                    // msb first on bit 0
                    st_next.dout = {7'h00, buf_data[7]};
                    st_next.shifter = {buf_data[6:0], 1'b0};
                    st_next.bit_cnt = 3'h1;
                end else begin
                    st_next.dout = buf_data;
                end
            end else begin
                st_next.dvalid = 1'b0;
            end
        end
    end

    // asynchronous clear: everything to defaults without a clock edge
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
            st_reg.lines <= rx_glue_pkg::LINES_RESET;
            st_reg.sym_div <= rx_glue_pkg::SYMDIV_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // stability counter read only by the pwm check
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hold_cnt <= '0;
        end else if (st_next.pwm != st_reg.pwm) begin
            hold_cnt <= '0;
        end else if (hold_cnt != 16'hFFFF) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign sample_clock_out_o = st_reg.ext_adc && st_reg.sclk;
    assign sample_i_o = st_reg.i_s;
    assign sample_q_o = st_reg.q_s;
    assign sample_valid_o = st_reg.s_valid;
    assign gain_pwm_out_o = st_reg.pwm;
    // lines 1 to 3 open drain: pull low for a zero, release for a one; line 4 driven only while its direction bit is set
    assign control_line_1_o = 1'b0;
    assign control_line_1_oe_o = !st_reg.lines[rx_glue_pkg::LN_L1];
    assign control_line_2_o = 1'b0;
    assign control_line_2_oe_o = !st_reg.lines[rx_glue_pkg::LN_L2];
    assign control_line_3_o = 1'b0;
    assign control_line_3_oe_o = !st_reg.lines[rx_glue_pkg::LN_L3];
    assign control_line_4_o = st_reg.lines[rx_glue_pkg::LN_L4_OUT];
    assign control_line_4_oe_o = st_reg.l4_dir;
    assign byte_data_out_o = st_reg.dout;
    assign byte_valid_out_o = st_reg.dvalid;
    assign byte_clock_out_o = st_reg.byte_clock_out;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_held_off;
        !st_reg.ready [*3];
    endsequence

    sequence s_sample_taken;
        st_reg.s_valid && st_reg.i_s == to_signed($past(sample_i_i), $past(st_reg.twos));
    endsequence

    a_clear_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $fell(reset_i) |-> s_held_off ##1 st_reg.ready)
        else $error("resume not on third edge after clear");

    a_line_defaults: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(st_reg.ready) |-> !control_line_1_oe_o && control_line_2_oe_o
            && control_line_3_oe_o && !control_line_4_oe_o)
        else $error("control lines not at defaults after clear");

    a_sclk_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(sample_clock_out_o) |-> $past(st_reg.ext_adc) || st_reg.ext_adc)
        else $error("sample clock moved with internal converters");

    a_sample_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(sample_clock_out_o) && st_reg.ready |-> s_sample_taken)
        else $error("sample not captured on sample clock rise");

    a_pwm_rate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $changed(gain_pwm_out_o) |-> $past(hold_cnt) >= 16'(MIN_HOLD - 1))
        else $error("pwm edge too soon");

    a_gain_refresh: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $changed(st_reg.gain) |-> st_reg.agc_cnt == 11'h000)
        else $error("gain changed off the 2048 symbol boundary");

    a_line4_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wb_ack_o && !wb_we_i && wb_adr_i == rx_glue_pkg::OFS_LINES && !st_reg.l4_dir
            |-> wb_dat_o[rx_glue_pkg::LN_L4_IN] == $past(st_reg.l4_in))
        else $error("line 4 level not readable");

    a_valid_edge: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $changed(byte_valid_out_o) || $changed(byte_data_out_o) |-> $rose(byte_clock_out_o))
        else $error("byte bus changed off byte clock rise");

    a_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule : rx_pin_glue

// ===== testbench/far_side_model.sv
// far side: external dual converter and the decoded byte receiver
// assumes the block's system clock and its sample clock output
`timescale 1ns/10ps
module far_side_model (
    // clock
    input wire logic clk_sys_i,
    // converter
    input wire logic sample_clock_out_i,
    output logic [rx_glue_pkg::SAMPLE_W-1:0] adc_i_o,
    output logic [rx_glue_pkg::SAMPLE_W-1:0] adc_q_o,
    // receiver
    input wire logic stall_i,
    output logic byte_ready_o
);
    initial begin
        adc_i_o = 6'h00;
        adc_q_o = 6'h00;
        byte_ready_o = 1'b0;
    end
    // new word only as the sample clock falls, so it is stable at each rise
    always @(posedge clk_sys_i) begin
        if (sample_clock_out_i) begin
            adc_i_o <= 6'($urandom);
            adc_q_o <= 6'($urandom);
        end
    end
    // random back-pressure; held low for the whole stall
    always @(posedge clk_sys_i) begin
        byte_ready_o <= !stall_i && ($urandom % 3 != 0);
    end
endmodule : far_side_model

// ===== testbench/rx_pin_glue_tb.sv
// self-checking bench for the receiver pin control block
// assumes the far side model and the package are compiled first
`timescale 1ns/10ps
module rx_pin_glue_tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] wdo, rd;
    logic ack, sclk, sval, pwm, stall, rdy, ival, irdy, bval, bclk, ext_lvl, line4, pwm_d;
    logic [5:0] ai, aq, si, sq;
    logic [7:0] gain, idat, bdat, sacc;
    wire [3:0] lo, loe;
    int mismatches = 0;
    int n_checks = 0;
    int wb_n, gap, nrise, sbits;
    logic [3:0] cfg = 4'h0;
    bit mon = 0;
    logic bclk_d = 1'b0;
    logic [7:0] q[$];
    // pull resistor level wins only while the block does not drive
    assign line4 = loe[3] ? lo[3] : ext_lvl;
    always #25 clk_sys_i = ~clk_sys_i;
    rx_pin_glue #(.SAMPLE_HALF(1), .BYTE_CLOCK_OUT_HALF(2), .BUF_DEPTH(2)) u_rx_pin_glue (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wdo),
        .wb_ack_o(ack), .sample_clock_out_o(sclk), .sample_i_i(ai), .sample_q_i(aq),
        .sample_i_o(si), .sample_q_o(sq), .sample_valid_o(sval), .gain_level_i(gain),
        .gain_pwm_out_o(pwm), .control_line_1_o(lo[0]), .control_line_1_oe_o(loe[0]),
        .control_line_2_o(lo[1]), .control_line_2_oe_o(loe[1]), .control_line_3_o(lo[2]),
        .control_line_3_oe_o(loe[2]), .control_line_4_i(line4), .control_line_4_o(lo[3]),
        .control_line_4_oe_o(loe[3]), .byte_in_valid_i(ival), .byte_in_ready_o(irdy),
        .byte_in_data_i(idat), .byte_ready_i(rdy), .byte_data_out_o(bdat),
        .byte_valid_out_o(bval), .byte_clock_out_o(bclk));
    far_side_model u_far_side_model (.clk_sys_i(clk_sys_i), .sample_clock_out_i(sclk),
        .adc_i_o(ai), .adc_q_o(aq), .stall_i(stall), .byte_ready_o(rdy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_sys_i);
            wb_n++;
        end while (ack !== 1'b1 && wb_n < 300);
        rd = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (wb_n >= 300) begin
            mismatches++;
            test_done();
        end
    endtask : wb
    task automatic send(input int n);
        int k;
        for (int b = 0; b < n; b++) begin
            k = 0;
            ival <= 1'b1;
            idat <= 8'($urandom);
            do begin
                @(posedge clk_sys_i);
                k++;
            end while (irdy !== 1'b1 && k < 400);
            q.push_back(idat);
            if (k >= 400) begin
                mismatches++;
                test_done();
            end
        end
        ival <= 1'b0;
    endtask : send
    task automatic drain();
        for (int k = 0; k < 600 && q.size() > 0; k++) @(posedge clk_sys_i);
        repeat (8) @(posedge clk_sys_i);
        chk(32'(q.size()), 32'h0000_0000);
    endtask : drain
    ////////////////////////////////////////////////////////////////////////////////
    // every result is compared mid-cycle, after the edge's updates landed
    always @(negedge clk_sys_i) begin
        if (mon && sval === 1'b1) begin
            chk(32'(si), 32'(cfg[1] ? ai : ai ^ 6'h20));
            chk(32'(sq), 32'(cfg[1] ? aq : aq ^ 6'h20));
        end
        if (mon && !cfg[0]) chk(32'(sclk), 32'h0000_0000);
        if (sclk === 1'b1 && mon) nrise++;
        if (pwm !== pwm_d && mon && cfg[0]) chk(32'(gap + 1 >= 2 * rx_glue_pkg::PWM_DIV), 32'h0000_0001);
        gap = (pwm !== pwm_d) ? 0 : gap + 1;
        pwm_d = pwm;
        if (bclk === 1'b1 && bclk_d === 1'b0 && bval === 1'b1) begin
            sacc = {sacc[6:0], bdat[0]};
            sbits++;
            if (cfg[3:2] != 2'h2 || sbits == 8) begin
                sbits = 0;
                chk(32'(q.size() > 0), 32'h0000_0001);
                if (q.size() > 0) chk(32'(cfg[3] ? sacc : bdat), 32'(q.pop_front()));
            end
        end
        bclk_d = bclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] v;
        logic e;
        logic l4m;
        logic pd;
        void'($urandom(32'ha2c196a9));
        {stall, ival, ext_lvl, pwm_d, gap, nrise, sbits} = '0;
        idat = 8'h00;
        gain = 8'hc5;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        chk(32'(loe), 32'h0000_0006);
        wb(1'b0, rx_glue_pkg::OFS_LINES, 32'h0);
        chk(rd, 32'h0000_0001);
        wb(1'b0, rx_glue_pkg::OFS_SYMDIV, 32'h0);
        chk(rd, 32'h0000_0001);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0000_0000);
        mon = 1;
        repeat (20) @(posedge clk_sys_i);
        l4m = 1'b0;
        pd = 1'b0;
        for (int i = 0; i < 6; i++) begin
            v = 5'($urandom);
            e = 1'($urandom);
            ext_lvl <= e;
            wb(1'b1, rx_glue_pkg::OFS_LINES, 32'(v));
            @(posedge clk_sys_i);
            chk(32'({loe, lo}), 32'({v[4], ~v[2:0], v[3], 3'h0}));
            // the pin level is only taken while line 4 is an input
            if (!pd || !v[4]) l4m = e;
            pd = v[4];
            wb(1'b0, rx_glue_pkg::OFS_LINES, 32'h0);
            chk(rd[8:0], {l4m, 3'h0, v});
        end
        wb(1'b1, rx_glue_pkg::OFS_LINES, 32'h0000_001f);
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        #1 chk(32'(loe), 32'h0000_0006);
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        wb(1'b0, rx_glue_pkg::OFS_LINES, 32'h0);
        chk(32'(wb_n >= 3), 32'h0000_0001);
        chk(rd, 32'h0000_0001);
        stall <= 1'b1;
        send(2);
        repeat (6) @(posedge clk_sys_i);
        chk(32'(irdy), 32'h0000_0000);
        stall <= 1'b0;
        drain();
        for (int m = 0; m < 3; m++) begin
            mon = 0;
            cfg = {2'(m), 1'(m), 1'b1};
            wb(1'b1, rx_glue_pkg::OFS_CONFIG, 32'(cfg));
            repeat (4) @(posedge clk_sys_i);
            mon = 1;
            nrise = 0;
            send(12);
            drain();
            chk(32'(nrise > 0), 32'h0000_0001);
            if (m == 1) chk(32'(bclk), 32'h0000_0000);
        end
        gain <= 8'h3a;
        for (int k = 0; k < 4000 && rd[7:0] !== 8'h3a; k++) begin
            wb(1'b0, rx_glue_pkg::OFS_STATUS, 32'h0);
        end
        chk(32'(rd[7:0]), 32'h0000_003a);
        test_done();
    end
endmodule : rx_pin_glue_tb
